// file: rtl/dsw_decoder.v
// Serial command word decoder for a dual 12-bit DAC
`include "dsw_defines.vh"
module dsw_decoder (
    input wire I_CLOCK,
    input wire I_RST,
    input wire I_CS_N,
    input wire I_SCLK,
    input wire I_DIN,
    output reg [11:0] O_DAC_A_CODE,
    output reg [11:0] O_DAC_B_CODE,
    output reg [11:0] O_BUFFER_CODE,
    output reg O_SPEED_FAST,
    output reg O_POWER_DOWN,
    output reg O_UPDATE
);
    // Pin order inside the synchroniser bank
    localparam PIN_DIN = 0;
    localparam PIN_SCLK = 1;
    localparam PIN_CS = 2;
    localparam NUM_PINS = 3;

    // Raw pins and their filtered levels
    wire [NUM_PINS-1:0] pin_raw;
    wire [NUM_PINS-1:0] pin_lvl;
    wire cs_n_lvl;
    wire sclk_lvl;
    wire din_lvl;

    // Edge detection of the filtered levels
    reg cs_n_d;
    reg sclk_d;
    wire cs_fall;
    wire cs_rise;
    wire sclk_fall;
    wire sclk_rise;

    // Word assembly
    reg [`DSW_WORD_BITS-1:0] shift;
    reg [`DSW_CNT_BITS-1:0] count;
    reg pending;
    reg [`DSW_WORD_BITS-1:0] word;
    reg [`DSW_WORD_BITS-1:0] next_shift;
    reg [`DSW_CNT_BITS-1:0] next_count;
    reg next_pending;
    reg [`DSW_WORD_BITS-1:0] next_word;
    wire [`DSW_WORD_BITS-1:0] shifted;
    wire count_full;
    wire count_empty;
    wire shift_step;
    wire last_step;
    wire cut_word;
    wire apply;

    // Decoded command
    wire [1:0] target_select;
    wire [`DSW_DATA_BITS-1:0] new_code;
    wire pd_word;
    wire write_en;
    reg load_a;
    reg load_b;
    reg b_from_buf;
    reg load_buf;
    reg sel_valid;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, one per pin
    assign pin_raw = {I_CS_N, I_SCLK, I_DIN};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_sync
            dsw_pin_sync u_sync (
                .I_CLOCK(I_CLOCK),
                .I_RST(I_RST),
                .i_pin(pin_raw[gi]),
                .o_level(pin_lvl[gi])
            );
        end
    endgenerate

    // Named views of the filtered levels
    assign cs_n_lvl = pin_lvl[PIN_CS];
    assign sclk_lvl = pin_lvl[PIN_SCLK];
    assign din_lvl = pin_lvl[PIN_DIN];

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection
    // Delayed levels; reset values match the synchroniser reset level of 0,
    // so only a pin that is high after reset, such as chip select, shows an edge while the filters settle
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            cs_n_d <= 1'b0;
            sclk_d <= 1'b0;
        end else begin
            cs_n_d <= cs_n_lvl;
            sclk_d <= sclk_lvl;
        end
    end

    // Falling serial edges count only while the chip is selected
    assign cs_fall = cs_n_d & ~cs_n_lvl;
    assign cs_rise = ~cs_n_d & cs_n_lvl;
    assign sclk_fall = sclk_d & ~sclk_lvl & ~cs_n_lvl;
    assign sclk_rise = ~sclk_d & sclk_lvl;

    ////////////////////////////////////////////////////////////////////////////
    // Bit counter conditions
    // Edges beyond the sixteenth are ignored until the next select
    assign count_full = (count == `DSW_CNT_FULL);
    assign count_empty = (count == `DSW_CNT_ZERO);
    assign shift_step = sclk_fall & ~cs_fall & ~count_full;
    assign last_step = shift_step & (count == `DSW_CNT_LAST);
    assign cut_word = cs_rise & ~count_full & ~count_empty;
    assign apply = pending & (sclk_rise | cs_rise);

    // Shift value with the new bit entering at the bottom, MSB first
    assign shifted = {shift[`DSW_WORD_BITS-2:0], din_lvl};

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the word assembly
    // Chip select fall restarts the count; a select rise cuts a short word
    always @* begin
        next_shift = shift;
        next_count = count;
        next_word = word;
        next_pending = pending;
        if (cs_fall) begin
            next_count = `DSW_CNT_ZERO;
        end else if (shift_step) begin
            next_shift = shifted;
            next_count = count + 1'b1;
            if (last_step) begin
                next_word = shifted;
                next_pending = 1'b1;
            end
        end else if (cut_word) begin
            next_word = shift;
            next_pending = 1'b1;
            next_count = `DSW_CNT_FULL;
        end
        if (apply) begin
            next_pending = 1'b0;
        end
    end

    // Word assembly registers
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            shift <= `DSW_WORD_RESET;
            count <= `DSW_CNT_ZERO;
            pending <= 1'b0;
            word <= `DSW_WORD_RESET;
        end else begin
            shift <= next_shift;
            count <= next_count;
            pending <= next_pending;
            word <= next_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    assign target_select = {word[`DSW_BIT_SEL_HI], word[`DSW_BIT_SEL_LO]};
    assign new_code = word[`DSW_DATA_BITS-1:0];
    assign pd_word = word[`DSW_BIT_PWDN];
    assign write_en = apply & ~pd_word;

    // Target latches chosen by the select code; code 11 touches nothing
    always @* begin
        load_a = 1'b0;
        load_b = 1'b0;
        b_from_buf = 1'b0;
        load_buf = 1'b0;
        sel_valid = 1'b1;
        case (target_select)
            `DSW_SEL_B_BUF: begin
                load_b = 1'b1;
                load_buf = 1'b1;
            end
            `DSW_SEL_BUF: begin
                load_buf = 1'b1;
            end
            `DSW_SEL_A_XFER: begin
                load_a = 1'b1;
                b_from_buf = 1'b1;
            end
            default: begin
                sel_valid = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all registered
    // Update pulse for every applied word except a reserved-code word without the power-down bit
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_UPDATE <= 1'b0;
        end else begin
            O_UPDATE <= apply & (pd_word | sel_valid);
        end
    end

    // Power-down follows bit 13 of every applied word
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_POWER_DOWN <= 1'b0;
        end else if (apply) begin
            O_POWER_DOWN <= pd_word;
        end
    end

    // Settling speed, left alone by a power-down word
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_SPEED_FAST <= 1'b0;
        end else if (write_en) begin
            O_SPEED_FAST <= word[`DSW_BIT_SPEED];
        end
    end

    // DAC A latch
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_DAC_A_CODE <= `DSW_CODE_RESET;
        end else if (write_en && load_a) begin
            O_DAC_A_CODE <= new_code;
        end
    end

    // DAC B latch, loaded directly or from the buffer together with A
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_DAC_B_CODE <= `DSW_CODE_RESET;
        end else if (write_en && load_b) begin
            O_DAC_B_CODE <= new_code;
        end else if (write_en && b_from_buf) begin
            O_DAC_B_CODE <= O_BUFFER_CODE;
        end
    end

    // Holding buffer
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_BUFFER_CODE <= `DSW_CODE_RESET;
        end else if (write_en && load_buf) begin
            O_BUFFER_CODE <= new_code;
        end
    end
endmodule // dsw_decoder

// file: rtl/dsw_defines.vh
// Constants of the serial command word decoder
// Operation
// - A command word is 16 bits: four program bits above twelve data bits.
// - Bit 15 select high, 14 speed, 13 power-down, 12 select low; data MSB first.
// - Select 00 loads B and buffer, 01 buffer, 10 A plus buffer to B, 11 reserved.
// - The twelve data bits become the new code of each selected target; here a word with the power-down bit set writes no target.
// - Speed bit 1 selects fast settling, 0 selects slow settling; here a power-down word leaves the speed unchanged.
// - The selected output changes on the rising serial edge after bit 0.
// - Buffer word then A word updates both outputs together after second word's bit 0.
// - Falling chip select starts a transfer; one bit shifts per falling serial edge.
// - The shift register moves to the latch after 16 bits or on chip select rise.
// - Reset clears all internal latches to zero.
`ifndef DSW_DEFINES_VH
`define DSW_DEFINES_VH
`define DSW_WORD_BITS 16
`define DSW_DATA_BITS 12
`define DSW_CNT_BITS 5
`define DSW_CNT_ZERO 5'h00
`define DSW_CNT_LAST 5'h0f
`define DSW_CNT_FULL 5'h10
`define DSW_BIT_SEL_HI 15
`define DSW_BIT_SPEED 14
`define DSW_BIT_PWDN 13
`define DSW_BIT_SEL_LO 12
`define DSW_SEL_B_BUF 2'b00
`define DSW_SEL_BUF 2'b01
`define DSW_SEL_A_XFER 2'b10
`define DSW_CODE_RESET 12'h000
`define DSW_WORD_RESET 16'h0000
`endif

// file: rtl/dsw_pin_sync.v
// Three-stage pin synchroniser with agreement filter
module dsw_pin_sync (
    input wire I_CLOCK,
    input wire I_RST,
    input wire i_pin,
    output reg o_level
);
    reg s1;
    reg s2;
    reg s3;

    // Level changes only once stages two and three agree
    always @(posedge I_CLOCK) begin
        if (I_RST) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
endmodule // dsw_pin_sync

// file: tb/dsw_decoder_props.sv
// Checker of the decoder outputs
module dsw_decoder_props (
    input wire I_CLOCK,
    input wire I_RST,
    input wire I_CS_N,
    input wire [11:0] O_DAC_A_CODE,
    input wire [11:0] O_DAC_B_CODE,
    input wire [11:0] O_BUFFER_CODE,
    input wire O_SPEED_FAST,
    input wire O_POWER_DOWN,
    input wire O_UPDATE
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    // Latches and modes move only as a written word dictates
    a_update_pulse: assert property (O_UPDATE |=> !O_UPDATE) else $error("update too long");
    a_codes_hold: assert property ($changed({O_DAC_A_CODE, O_DAC_B_CODE, O_BUFFER_CODE})
        |-> O_UPDATE || $past(O_UPDATE)) else $error("code moved without update");
    a_b_from_buf: assert property ($changed(O_DAC_B_CODE) |-> O_DAC_B_CODE == O_BUFFER_CODE) else $error("b off");
    a_xfer_both: assert property ($changed(O_DAC_A_CODE) |-> O_DAC_B_CODE == O_BUFFER_CODE) else $error("no copy");
    a_pd_freeze: assert property ($rose(O_POWER_DOWN)
        |-> $stable({O_DAC_A_CODE, O_DAC_B_CODE, O_BUFFER_CODE, O_SPEED_FAST})) else $error("pd word leaked");
    a_speed_cause: assert property ($changed(O_SPEED_FAST) |-> !O_POWER_DOWN) else $error("speed moved");
    a_upd_in_frame: assert property (O_UPDATE |-> !$past(I_CS_N, 8)) else $error("update outside frame");
    a_reset_zero: assert property (disable iff (1'b0) I_RST |=> {O_DAC_A_CODE, O_DAC_B_CODE, O_BUFFER_CODE,
        O_SPEED_FAST, O_POWER_DOWN, O_UPDATE} == 39'h0) else $error("reset not clear");
endmodule // dsw_decoder_props
bind dsw_decoder dsw_decoder_props u_props (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_CS_N(I_CS_N),
    .O_DAC_A_CODE(O_DAC_A_CODE), .O_DAC_B_CODE(O_DAC_B_CODE), .O_BUFFER_CODE(O_BUFFER_CODE),
    .O_SPEED_FAST(O_SPEED_FAST), .O_POWER_DOWN(O_POWER_DOWN), .O_UPDATE(O_UPDATE));

// file: tb/dsw_decoder_tb_top.sv
// Bench for the serial command word decoder
module dsw_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_CLOCK = 1'b0;
    logic I_RST = 1'b1;
    wire cs_n, sclk, din, speed_select, pd, upd;
    wire [11:0] dac_a, dac_b, buf_c;
    logic [37:0] exp_st = '0;
    int num_errors = 0;
    int n_tests = 0;
    int upd_seen = 0;
    logic [15:0] w;
    // Count update pulses of the current word
    always @(posedge I_CLOCK) if (upd) upd_seen++;
    logic [15:0] corner [6] = '{16'h1abc, 16'h8123, 16'h0fff, 16'hd555, 16'h2000, 16'h4321};
    initial forever #2 I_CLOCK = ~I_CLOCK;
    dsw_host_model host (.i_clk(I_CLOCK), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
    dsw_decoder dut (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_CS_N(cs_n), .I_SCLK(sclk), .I_DIN(din),
        .O_DAC_A_CODE(dac_a), .O_DAC_B_CODE(dac_b), .O_BUFFER_CODE(buf_c), .O_SPEED_FAST(speed_select),
        .O_POWER_DOWN(pd), .O_UPDATE(upd));
    // Expected {a, b, buffer, speed, power-down} after one word
    function automatic logic [37:0] next_st(input logic [37:0] s, input logic [15:0] w);
        if (w[13]) return {s[37:1], 1'b1};
        case ({w[15], w[12]})
            2'b00: return {s[37:26], w[11:0], w[11:0], w[14], 1'b0};
            2'b01: return {s[37:14], w[11:0], w[14], 1'b0};
            2'b10: return {w[11:0], s[13:2], s[13:2], w[14], 1'b0};
            default: return {s[37:2], w[14], 1'b0};
        endcase
    endfunction
    task automatic check(input logic [37:0] seen, input logic [37:0] want);
        n_tests++;
        if (seen !== want) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Corner words (buffer, joint update, reserved, power-down) then random words
    initial begin
        void'($urandom(45));
        repeat (3) @(negedge I_CLOCK);
        I_RST = 1'b0;
        check({dac_a, dac_b, buf_c, speed_select, pd}, exp_st);
        for (int k = 0; k < 30; k++) begin
            w = k < 6 ? corner[k] : 16'($urandom);
            exp_st = next_st(exp_st, w);
            upd_seen = 0;
            host.send(w);
            check({dac_a, dac_b, buf_c, speed_select, pd}, exp_st);
            check(38'(upd_seen), 38'(w[13] || {w[15], w[12]} != 2'b11));
            $display("test %0d done", k);
            corner[k % 6] = 16'($urandom);
        end
        finish_test();
    end
    initial begin
        #200us;
        num_errors++;
        finish_test();
    end
endmodule // dsw_decoder_tb_top

// file: tb/dsw_host_model.sv
// Host serial master model
module dsw_host_model (
    input wire i_clk,
    output logic o_cs_n = 1'b1,
    output logic o_sclk = 1'b0,
    output logic o_din = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // One word as two bytes under one select, 32 ns serial clock, still outside frames
    task automatic send(input logic [15:0] w);
        o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (4) @(negedge i_clk);
            o_sclk = 1'b1;
            o_din = w[i];
            repeat (4) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (4) @(negedge i_clk);
        o_sclk = 1'b1;
        o_din = ~o_din;
        repeat (4) @(negedge i_clk);
        o_sclk = 1'b0;
        repeat (8) @(negedge i_clk);
        o_cs_n = 1'b1;
        repeat (16) @(negedge i_clk);
    endtask
endmodule // dsw_host_model
